// file: core/iosp_defs.vh
`ifndef IOSP_DEFS_VH
`define IOSP_DEFS_VH

// Register indices; the byte address is four times the index.
`define IOSP_IDX_SPARE 4'hC
`define IOSP_IDX_IO_LVL 4'hD
`define IOSP_IDX_PIN_STS 4'hE
`define IOSP_IDX_IN_CTL 4'hF

// Byte addresses on the register bus.
`define IOSP_ADDR_SPARE 8'h30
`define IOSP_ADDR_IO_LVL 8'h34
`define IOSP_ADDR_PIN_STS 8'h38
`define IOSP_ADDR_IN_CTL 8'h3C

// Field positions of the I/O level control register.
`define IOSP_HV_SEL_BIT 7
`define IOSP_OVR_BIT 6
`define IOSP_MODE_HI 5
`define IOSP_MODE_LO 4

// Supply mode encodings.
`define IOSP_MODE_1V8 2'h0
`define IOSP_MODE_3V3 2'h3

// Reset values.
`define IOSP_RST_SPARE 8'h00
`define IOSP_RST_IO_LVL 8'h09
`define IOSP_RST_STS_HI 4'h0
`define IOSP_RST_IN_CTL 8'h7F

// AXI responses.
`define IOSP_RESP_OKAY 2'h0
`define IOSP_RESP_SLVERR 2'h2

`endif

// file: core/iosp_pin_sampler.v
`timescale 1ns/1ps
`default_nettype none

// Samples the general-purpose pins into flip-flops; a disabled input reads as zero.
module iosp_pin_sampler #(
   parameter PINS = 4
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [PINS-1:0] pin_in,
   input wire [PINS-1:0] pin_in_en,
   output reg [PINS-1:0] pin_level_q
);
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_level_q[i] <= 1'b0;
            end else begin
               pin_level_q[i] <= pin_in[i] & pin_in_en[i]; // [R6] [R7]
            end
         end
      end
   endgenerate
endmodule

`default_nettype wire

// file: core/iosp_regs.v
// Operation
// [R1] Bit 7 of the I/O level control register selects 1.8 V (0) or 3.3 V (1) signalling.
// [R2] With the override clear, the select bit reads back the detected supply level.
// [R3] With the override bit 6 clear, select and supply mode follow the detected supply.
// [R4] With the override bit 6 set, the software-written select and supply mode apply.
// [R5] Supply mode bits 5:4 decode 00 as 1.8 V and 11 as 3.3 V, reading detected without override.
// [R6] Bits 3:0 of the pin status register show the four pin levels, bit n for pin n.
// [R7] Bits 3:0 of the input control register enable each pin input and reset to one.
// [R8] Override, select and supply mode reset to zero so the detected level governs.
// [R9] Software keeps reserved fields at their reset values by read-modify-write.
`timescale 1ns/1ps
`default_nettype none
`include "iosp_defs.vh"

module iosp_regs #(
   parameter PINS = 4
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire io_supply_rail,
   input wire [PINS-1:0] pin_in,
   output reg high_voltage_io_select,
   output reg [1:0] supply_mode,
   output wire [PINS-1:0] pin_input_enable
);
   // Stored register bytes and their next values.
   reg [7:0] spare_q;
   reg [7:0] spare_d;
   reg [7:0] io_lvl_q;
   reg [7:0] io_lvl_d;
   reg [3:0] sts_hi_q;
   reg [3:0] sts_hi_d;
   reg [7:0] in_ctl_q;
   reg [7:0] in_ctl_d;

   // Write channel holding registers and their next values.
   reg [7:0] aw_addr_q;
   reg [7:0] aw_addr_d;
   reg aw_have_q;
   reg aw_have_d;
   reg [7:0] w_data_q;
   reg [7:0] w_data_d;
   reg w_lane_q;
   reg w_lane_d;
   reg w_have_q;
   reg w_have_d;
   reg bvalid_d;
   reg [1:0] bresp_d;

   // Read channel next values.
   reg rvalid_d;
   reg [31:0] rdata_d;
   reg [1:0] rresp_d;

   // Combinational helpers.
   reg [7:0] rd_byte;
   reg [1:0] det_mode;
   wire [PINS-1:0] pin_level_q;
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire wr_go;
   wire wr_commit;
   wire ovr;

   // Accepts a word address in the register window; other addresses answer with an error.
   function mapped;
      input [7:0] addr;
      begin
         mapped = (addr == `IOSP_ADDR_SPARE) || (addr == `IOSP_ADDR_IO_LVL) ||
                  (addr == `IOSP_ADDR_PIN_STS) || (addr == `IOSP_ADDR_IN_CTL);
      end
   endfunction

   // Gives the supply mode code that stands for a detected rail level.
   function [1:0] mode_of_rail;
      input rail;
      begin
         if (rail) begin
            mode_of_rail = `IOSP_MODE_3V3;
         end else begin
            mode_of_rail = `IOSP_MODE_1V8;
         end
      end
   endfunction

   assign ovr = io_lvl_q[`IOSP_OVR_BIT];
   assign pin_input_enable = in_ctl_q[PINS-1:0];

   // The pins follow the detected rail unless software has set the override.
   always @* begin
      det_mode = mode_of_rail(io_supply_rail); // [R5]
      if (ovr) begin
         high_voltage_io_select = io_lvl_q[`IOSP_HV_SEL_BIT]; // [R4] [R1]
         supply_mode = io_lvl_q[`IOSP_MODE_HI:`IOSP_MODE_LO]; // [R4]
      end else begin
         high_voltage_io_select = io_supply_rail; // [R3] [R1]
         supply_mode = det_mode; // [R3]
      end
   end

   iosp_pin_sampler #(
      .PINS(PINS)
   ) u_sampler (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(pin_in),
      .pin_in_en(pin_input_enable),
      .pin_level_q(pin_level_q)
   );

   // Write path: address and data are taken independently, response after both.
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

   // A write whose low byte lane is off is answered but leaves the registers alone.
   assign wr_commit = wr_go && w_lane_q;

   always @* begin
      aw_addr_d = aw_addr_q;
      aw_have_d = aw_have_q;
      w_data_d = w_data_q;
      w_lane_d = w_lane_q;
      w_have_d = w_have_q;
      bvalid_d = s_axi_bvalid;
      bresp_d = s_axi_bresp;
      if (aw_take) begin
         aw_addr_d = s_axi_awaddr;
         aw_have_d = 1'b1;
      end
      if (w_take) begin
         w_data_d = s_axi_wdata[7:0];
         w_lane_d = s_axi_wstrb[0];
         w_have_d = 1'b1;
      end
      if (wr_go) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         if (mapped(aw_addr_q)) begin
            bresp_d = `IOSP_RESP_OKAY;
         end else begin
            bresp_d = `IOSP_RESP_SLVERR;
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_addr_q <= 8'h00;
         aw_have_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOSP_RESP_OKAY;
      end else begin
         aw_addr_q <= aw_addr_d;
         aw_have_q <= aw_have_d;
         w_data_q <= w_data_d;
         w_lane_q <= w_lane_d;
         w_have_q <= w_have_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_bresp <= bresp_d;
      end
   end

   // Register file: reserved fields are stored so that read-modify-write keeps them.
   always @* begin
      spare_d = spare_q;
      io_lvl_d = io_lvl_q;
      sts_hi_d = sts_hi_q;
      in_ctl_d = in_ctl_q;
      if (wr_commit) begin
         case (aw_addr_q)
            `IOSP_ADDR_SPARE: begin
               spare_d = w_data_q;
            end
            `IOSP_ADDR_IO_LVL: begin
               io_lvl_d = w_data_q; // [R1] [R4] [R9]
            end
            `IOSP_ADDR_PIN_STS: begin
               sts_hi_d = w_data_q[7:4];
            end
            `IOSP_ADDR_IN_CTL: begin
               in_ctl_d = w_data_q; // [R7] [R9]
            end
            default: begin
               spare_d = spare_q;
            end
         endcase
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         spare_q <= `IOSP_RST_SPARE;
         io_lvl_q <= `IOSP_RST_IO_LVL; // [R8]
         sts_hi_q <= `IOSP_RST_STS_HI;
         in_ctl_q <= `IOSP_RST_IN_CTL; // [R7]
      end else begin
         spare_q <= spare_d;
         io_lvl_q <= io_lvl_d;
         sts_hi_q <= sts_hi_d;
         in_ctl_q <= in_ctl_d;
      end
   end

   // Read path: one read at a time, answered the cycle after the address is taken.
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   // Without the override the level fields read back what the rail shows, not what was written.
   always @* begin
      case (s_axi_araddr)
         `IOSP_ADDR_SPARE: begin
            rd_byte = spare_q;
         end
         `IOSP_ADDR_IO_LVL: begin
            if (ovr) begin
               rd_byte = io_lvl_q;
            end else begin
               rd_byte = {io_supply_rail, 1'b0, det_mode, io_lvl_q[3:0]}; // [R2] [R5]
            end
         end
         `IOSP_ADDR_PIN_STS: begin
            rd_byte = {sts_hi_q, pin_level_q}; // [R6]
         end
         `IOSP_ADDR_IN_CTL: begin
            rd_byte = in_ctl_q;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always @* begin
      rvalid_d = s_axi_rvalid;
      rdata_d = s_axi_rdata;
      rresp_d = s_axi_rresp;
      if (ar_take) begin
         rvalid_d = 1'b1;
         rdata_d = {24'h000000, rd_byte};
         if (mapped(s_axi_araddr)) begin
            rresp_d = `IOSP_RESP_OKAY;
         end else begin
            rresp_d = `IOSP_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IOSP_RESP_OKAY;
      end else begin
         s_axi_rvalid <= rvalid_d;
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rresp_d;
      end
   end

   // The rail level and the pins are taken as already synchronous to the register clock.
   // Only the low byte of each word carries a register; the upper bytes read as zero.
   // An unmapped address is answered with an error and never alters a register.
endmodule

`default_nettype wire

// file: sim/iosp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module iosp_pin_model (
   input wire logic [3:0] level_set,
   input wire logic rail_high,
   output logic [3:0] pin_in,
   output logic io_supply_rail
);
   assign pin_in = level_set;
   assign io_supply_rail = rail_high;
endmodule
`default_nettype wire

// file: sim/iosp_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module iosp_regs_sva (
   input wire logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic s_axi_bvalid, s_axi_bready, io_supply_rail, high_voltage_io_select,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [1:0] supply_mode,
   input wire logic [3:0] pin_input_enable
);
   logic wp_q, ovr_q, sel_q;
   logic [1:0] mode_q;
   logic [3:0] en_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid;
   endsequence
   // Mirrors the written control fields; the checks on the control outputs pause while a write is in flight.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {wp_q, ovr_q, sel_q, mode_q, en_q} <= 9'h00F;
      end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid) begin
         wp_q <= 1'h1;
         if (s_axi_awaddr == 8'h34) {sel_q, ovr_q, mode_q} <= s_axi_wdata[7:4];
         if (s_axi_awaddr == 8'h3C) en_q <= s_axi_wdata[3:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         wp_q <= 1'h0;
      end
   end
   a_rail_to_sel: assert property (!wp_q && !ovr_q |-> high_voltage_io_select == io_supply_rail)
      else $error("select does not follow supply");
   a_rail_to_mode: assert property (!wp_q && !ovr_q |-> supply_mode == {2{io_supply_rail}})
      else $error("mode does not follow supply");
   a_reg_to_sel: assert property (!wp_q && ovr_q |-> high_voltage_io_select == sel_q)
      else $error("select ignores written value");
   a_reg_to_mode: assert property (!wp_q && ovr_q |-> supply_mode == mode_q)
      else $error("mode ignores written value");
   a_reset_detect: assert property ($rose(rst_n) |-> high_voltage_io_select == io_supply_rail && supply_mode == {2{io_supply_rail}})
      else $error("select wrong after reset");
   a_enable_reg: assert property (!wp_q |-> pin_input_enable == en_q)
      else $error("input enables wrong");
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule
bind iosp_regs iosp_regs_sva i_iosp_regs_sva (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .io_supply_rail, .high_voltage_io_select,
   .s_axi_awaddr, .s_axi_wdata, .supply_mode, .pin_input_enable);
`default_nettype wire

// file: sim/tb_iosp_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_iosp_regs;
   logic ref_clk = 1'h0, rst_n = 1'h0, rail_high = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, data;
   logic [3:0] s_axi_wstrb = 4'h1, level_set = 4'h0, pin_in, pin_input_enable;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic high_voltage_io_select, io_supply_rail;
   logic [1:0] s_axi_bresp, s_axi_rresp, supply_mode, resp;
   int err_count = 0, cmp_count = 0, cyc = 0;
   iosp_regs i_iosp_regs (.*);
   iosp_pin_model i_iosp_pin_model (.*);
   always #2 ref_clk = ~ref_clk;
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      do @(posedge ref_clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      {data, resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("read data", e, data);
      chk("read resp", 32'h0, resp);
   endtask
   task t_reset;
      rchk(8'h30, 32'h00);
      rchk(8'h34, 32'h09);
      rchk(8'h3C, 32'h7F);
      chk("enable", 32'hF, pin_input_enable);
   endtask
   task t_detect;
      rail_high <= 1'h1;
      rchk(8'h34, 32'hB9);
      chk("select", 32'h1, high_voltage_io_select);
      chk("mode", 32'h3, supply_mode);
   endtask
   task t_override;
      wr(8'h34, 32'h49);
      chk("select", 32'h0, high_voltage_io_select);
      chk("mode", 32'h0, supply_mode);
      rchk(8'h34, 32'h49);
      rail_high <= 1'h0;
      wr(8'h34, 32'hF9);
      chk("select", 32'h1, high_voltage_io_select);
      chk("mode", 32'h3, supply_mode);
      wr(8'h34, 32'h09);
   endtask
   task t_pins;
      level_set <= 4'hB;
      wr(8'h3C, 32'h75);
      chk("enable", 32'h5, pin_input_enable);
      rchk(8'h38, 32'h01);
      wr(8'h3C, 32'h7F);
      rchk(8'h38, 32'h0B);
   endtask
   task t_spare;
      wr(8'h30, 32'hA5);
      rchk(8'h30, 32'hA5);
      s_axi_wstrb <= 4'h0;
      wr(8'h30, 32'h11);
      s_axi_wstrb <= 4'h1;
      rchk(8'h30, 32'hA5);
      wr(8'h38, 32'h50);
      rchk(8'h38, 32'h5B);
      rst_n <= 1'h0;
      @(posedge ref_clk);
      rst_n <= 1'h1;
      rchk(8'h30, 32'h00);
      rchk(8'h38, 32'h0B);
      rchk(8'h3C, 32'h7F);
      rchk(8'h34, 32'h09);
   endtask
   task t_unmapped;
      wr(8'h40, 32'h5A);
      chk("write resp", 32'h2, resp);
      rd(8'h40);
      chk("read resp", 32'h2, resp);
      chk("read data", 32'h0, data);
   endtask
   task print_verdict;
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         print_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_reset;
      t_detect;
      t_override;
      t_pins;
      t_spare;
      t_unmapped;
      print_verdict;
   end
endmodule
`default_nettype wire
